// ==== rtl/rcsg_core.sv ====
// reset merger, malfunction reset pulse and clock switch guard
//
// Contract
// RULE1 - four sources: pin, trap, watchdog, clock
// RULE2 - malfunction reset drives pin low 24 cycles
// RULE3 - no power-on clear; spurious pulse possible; here rst_n_i zeroes the pulse counter and flag
// RULE4 - reset clears interrupt enables and latches
// RULE5 - reset clears prescaler, leaves watchdog enabled
// RULE6 - outside holds pin low twelve fast cycles
// RULE7 - after release, start at top vector
// RULE8 - fetch from sfr, dbr, ram traps
// RULE9 - trap response and areas are selectable
// RULE10 - illegal oscillator disable raises clock reset
// RULE11 - oscillators keep running after offending write
// RULE12 - slow switch: set select, then clear fast
// RULE13 - warm slow oscillator with timer pair first
// RULE14 - fast return: enable, warm up, clear select
// RULE15 - stay on slow clock until clocks aligned
// RULE16 - pin low ends slow; start fast single
// RULE17 - merged reset released synchronously to clock
`timescale 1ns/1ps
`include "rcsg_regs.svh"
module rcsg_core
	import rcsg_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// reset pin, open drain
	input  wire logic        reset_pin_i,
	output logic             reset_pin_o,
	output logic             reset_pin_oe_o,
	// other malfunction sources
	input  wire logic        wdt_reset_req_i,
	// instruction fetch watch
	input  wire logic        fetch_i,
	input  wire logic [15:0] fetch_addr_i,
	input  wire logic        ram_trap_select_i,
	input  wire logic        trap_to_reset_i,
	input  wire logic        trap_area_sfr_i,
	input  wire logic        trap_area_dbr_i,
	// system_control_two write port
	input  wire logic        sysctl_we_i,
	input  wire logic [7:0]  sysctl_wdata_i,
	output logic [7:0]       system_control_two_o,
	// results
	output logic             int_reset_o,
	output logic             trap_int_o,
	output logic             fast_osc_en_o,
	output logic             slow_osc_en_o,
	output logic             cpu_on_slow_o,
	output logic             clear_int_state_o,
	output logic             clear_prescaler_o,
	output logic             watchdog_enable_o,
	output logic [15:0]      reset_vector_addr_o
);
	rcsg_state_s st;       // registered state
	rcsg_state_s next_st;  // next state
	logic        pin_low;  // synchronised pin level low
	logic        trap_hit; // fetch hits a trapped area
	logic        clk_rst;  // illegal oscillator write
	logic        mal_req;  // any malfunction request
	logic        xen_clr;  // write clears fast enable
	logic        xten_clr; // write clears slow enable

	// the pin reads back our own drive too, so a malfunction pulse
	// also shows up as pin_low and stretches the merged reset
	assign pin_low = ~st.pin_sync[1];

	// trap decode; areas individually selectable
	// each area has its own enable so software can narrow the
	// trapped space, e.g. while it runs code copied into ram.
	// the decode is purely combinational on the fetch strobe; the
	// response (reset or interrupt) is chosen further down.
	// a fetch that hits no enabled area is simply ignored here
	always_comb begin
		trap_hit = 1'b0;
		if (fetch_i) begin
			if (trap_area_sfr_i && fetch_addr_i >= `RCSG_SFR_BASE
			    && fetch_addr_i <= `RCSG_SFR_TOP) begin
				trap_hit = 1'b1; // RULE8 RULE9
			end
			if (trap_area_dbr_i && fetch_addr_i >= `RCSG_DBR_BASE
			    && fetch_addr_i <= `RCSG_DBR_TOP) begin
				trap_hit = 1'b1; // RULE8 RULE9
			end
			if (ram_trap_select_i && fetch_addr_i >= `RCSG_RAM_BASE
			    && fetch_addr_i <= `RCSG_RAM_TOP) begin
				trap_hit = 1'b1; // RULE8
			end
		end
	end

	// illegal disable detection against current select bit
	// a write that would stop the oscillator named by the current select bit is
	// turned into a clock reset instead of being stored; this is
	// the only guard against software dead-locking the clock tree.
	// clearing both enables traps even when they were already off
	always_comb begin
		xen_clr  = sysctl_we_i && st.sysctl[`RCSG_XEN_BIT] && !sysctl_wdata_i[`RCSG_XEN_BIT];
		xten_clr = sysctl_we_i && st.sysctl[`RCSG_XTEN_BIT]
		           && !sysctl_wdata_i[`RCSG_XTEN_BIT];
		clk_rst  = sysctl_we_i && (
		           (!sysctl_wdata_i[`RCSG_XEN_BIT] && !sysctl_wdata_i[`RCSG_XTEN_BIT])
		           || (xen_clr && !st.sysctl[`RCSG_SYSCK_BIT])
		           || (xten_clr && st.sysctl[`RCSG_SYSCK_BIT])); // RULE10
		mal_req  = wdt_reset_req_i || clk_rst || (trap_hit && trap_to_reset_i); // RULE1
	end

	// next state
	// everything the block remembers lives in one struct, so the
	// whole update is written here and registered in one place.
	// the malfunction counter ignores new requests while it runs:
	// a second source during the pulse only keeps reset asserted,
	// it never lengthens the pin drive beyond its fixed length.
	// internal reset has the last word over mode and register
	always_comb begin
		next_st = st;
		next_st.pin_sync = {st.pin_sync[0], reset_pin_i};
		next_st.trap_int = trap_hit && !trap_to_reset_i; // RULE9
		// malfunction pulse: fixed length counter
		if (mal_req && !st.mal_act) begin
			next_st.mal_act = 1'b1; // RULE2
			next_st.mal_cnt = 5'(`RCSG_MAL_RST_CYC - 1);
		end else if (st.mal_act) begin
			if (st.mal_cnt == 5'h00) begin
				next_st.mal_act = 1'b0;
			end else begin
				next_st.mal_cnt = st.mal_cnt - 5'h01; // RULE2
			end
		end
		// merged reset, released on a clock edge only
		next_st.int_rst = pin_low || st.mal_act || mal_req; // RULE17 RULE1
		// register write, offending write keeps oscillators on
		if (sysctl_we_i) begin
			if (clk_rst) begin
				next_st.sysctl = st.sysctl; // RULE11
			end else begin
				next_st.sysctl = sysctl_wdata_i;
			end
		end
		// clock mode tracking
		unique case (st.mode)
			RCSG_FAST: begin
				if (next_st.sysctl[`RCSG_SYSCK_BIT]) begin
					next_st.mode = RCSG_SLOW; // RULE12
				end
			end
			RCSG_SLOW: begin
				if (!next_st.sysctl[`RCSG_SYSCK_BIT]) begin
					next_st.mode     = RCSG_SYNC; // RULE15
					next_st.sync_cnt = 3'(`RCSG_SYNC_CYC - 1);
				end
			end
			RCSG_SYNC: begin
				if (next_st.sysctl[`RCSG_SYSCK_BIT]) begin
					next_st.mode = RCSG_SLOW;
				end else if (st.sync_cnt == 3'h0) begin
					next_st.mode = RCSG_FAST; // RULE15
				end else begin
					next_st.sync_cnt = st.sync_cnt - 3'h1;
				end
			end
		endcase
		// internal reset ends slow mode, restarts in fast single mode
		if (st.int_rst) begin
			next_st.mode   = RCSG_FAST; // RULE16
			next_st.sysctl = `RCSG_SYSCTL_RST;
		end
	end

	// state register; only constants are loaded in the reset branch
	// the merged reset comes up asserted so the cpu starts held,
	// and the pin synchroniser starts at the idle high level
	// state register; constants only at reset.  RULE3: the pulse
	// counter is not primed, real silicon may glitch; here it is zero
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st          <= '0;
			st.pin_sync <= 2'h3;
			st.sysctl   <= `RCSG_SYSCTL_RST;
			st.mode     <= RCSG_FAST;
			st.int_rst  <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// outputs
	// the pin is open drain: data is always low, the enable decides.
	// the clear strobes follow the merged reset so the interrupt
	// controller and the prescaler see exactly the cpu reset window.
	// the watchdog stays enabled through and after every reset
	assign reset_pin_o          = 1'b0;
	assign reset_pin_oe_o       = st.mal_act; // RULE2
	assign int_reset_o          = st.int_rst;
	assign trap_int_o           = st.trap_int;
	assign system_control_two_o = st.sysctl;
	assign fast_osc_en_o        = st.sysctl[`RCSG_XEN_BIT];
	assign slow_osc_en_o        = st.sysctl[`RCSG_XTEN_BIT];
	assign cpu_on_slow_o        = (st.mode != RCSG_FAST); // RULE15
	assign clear_int_state_o    = st.int_rst; // RULE4
	assign clear_prescaler_o    = st.int_rst; // RULE5
	assign watchdog_enable_o    = 1'b1;       // RULE5
	assign reset_vector_addr_o  = `RCSG_RESET_VECTOR_LO; // RULE7

	// checks
	// all properties run on the one clock and sleep during rst_n_i

	// pin drive must last at least eight cycles once started
	a_mal_pulse_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(reset_pin_oe_o) |-> reset_pin_oe_o [*8]) // RULE2
		else $error("malfunction pulse too short");
	// and must end near its fixed length
	a_mal_pulse_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(st.mal_act) |-> ##[20:26] !st.mal_act) // RULE2
		else $error("malfunction pulse too long");
	// an illegal oscillator write starts the pulse
	a_clk_reset_raise: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		clk_rst && !st.mal_act |=> reset_pin_oe_o && int_reset_o) // RULE10
		else $error("clock reset not raised");
	// the offending write is not stored
	a_osc_kept_on: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		clk_rst && !st.int_rst |=> system_control_two_o == $past(st.sysctl)) // RULE11
		else $error("oscillator stopped by bad write");
	// trap configured for reset gives reset
	a_trap_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		trap_hit && trap_to_reset_i |=> int_reset_o) // RULE8
		else $error("trap did not reset");
	// trap configured for interrupt gives the pulse
	a_trap_irq: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		trap_hit && !trap_to_reset_i |=> trap_int_o) // RULE9
		else $error("trap interrupt missing");
	// reset always returns the cpu to the fast clock
	a_reset_fast: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		int_reset_o |=> !cpu_on_slow_o) // RULE16
		else $error("reset left slow mode");
	// alignment wait keeps the slow clock for four cycles
	a_sync_wait: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$rose(st.mode == RCSG_SYNC) |-> cpu_on_slow_o [*4]) // RULE15
		else $error("left slow clock too early");
	// watchdog request reaches the merged reset
	a_wdt_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wdt_reset_req_i |=> int_reset_o) // RULE1
		else $error("watchdog reset lost");
	// a low pin keeps the merged reset asserted
	a_pin_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		pin_low |=> int_reset_o) // RULE17
		else $error("pin low not merged");

	// open drain data never drives high
	a_pin_data_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		reset_pin_o == 1'b0) // RULE2
		else $error("reset pin driven high");
	// pin drive is always inside the internal reset window
	a_oe_in_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		reset_pin_oe_o |-> int_reset_o) // RULE2
		else $error("pin driven outside reset");
	// a running pulse is not cut short
	a_mal_no_cut: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		st.mal_act && st.mal_cnt != 5'h00 |=> st.mal_act) // RULE2
		else $error("malfunction pulse cut");
	// interrupt state clear follows the merged reset
	a_clear_int: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		clear_int_state_o == int_reset_o) // RULE4
		else $error("interrupt clear mismatch");
	// prescaler clear follows the merged reset
	a_clear_presc: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		clear_prescaler_o == int_reset_o) // RULE5
		else $error("prescaler clear mismatch");
	// watchdog stays enabled
	a_wdt_enabled: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		watchdog_enable_o) // RULE5
		else $error("watchdog disabled");
	// start address is the top vector
	a_vector_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		reset_vector_addr_o == `RCSG_RESET_VECTOR_LO) // RULE7
		else $error("wrong reset vector");
	// reset reloads the control register
	a_sysctl_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		int_reset_o |=> system_control_two_o == `RCSG_SYSCTL_RST) // RULE16
		else $error("control not reloaded by reset");
	// mode register stays one-hot
	a_mode_onehot: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$onehot(st.mode)) // RULE15
		else $error("clock mode not one-hot");
	// leaving the slow clock other than by reset goes through the alignment wait
	a_fall_sync: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(cpu_on_slow_o) && !$past(st.int_rst) |-> $past(st.mode == RCSG_SYNC)) // RULE15
		else $error("slow clock left without alignment");
	// all areas off means no trap at all
	a_trap_masked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!trap_area_sfr_i && !trap_area_dbr_i && !ram_trap_select_i |-> !trap_hit) // RULE9
		else $error("trap from disabled area");
	// clearing both enables is always a clock reset
	a_both_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		sysctl_we_i && sysctl_wdata_i[7:6] == 2'b00 |-> clk_rst) // RULE10
		else $error("both oscillators off accepted");
	// at least one oscillator survives a clock reset
	a_osc_survive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		clk_rst |=> fast_osc_en_o || slow_osc_en_o) // RULE11
		else $error("all oscillators stopped");
	// with no source left the merged reset drops on the next edge
	a_rst_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!pin_low && !st.mal_act && !mal_req |=> !int_reset_o) // RULE17
		else $error("merged reset stuck");
endmodule

// ==== rtl/rcsg_pkg.sv ====
// types for the reset and clock switch guard
package rcsg_pkg;
	// clock mode states, one-hot
	typedef enum logic [2:0] {
		RCSG_FAST = 3'h1,  // fast clock drives the cpu
		RCSG_SYNC = 3'h2,  // select cleared, still on slow clock until aligned
		RCSG_SLOW = 3'h4   // slow clock drives the cpu
	} rcsg_mode_e;
	// whole block state
	typedef struct packed {
		logic [1:0]  pin_sync;   // reset pin synchroniser
		logic [4:0]  mal_cnt;    // malfunction reset pulse counter
		logic        mal_act;    // malfunction reset pulse running
		logic [7:0]  sysctl;     // system_control_two image
		rcsg_mode_e  mode;       // clock mode
		logic [2:0]  sync_cnt;   // clock alignment wait
		logic        int_rst;    // merged internal reset
		logic        trap_int;   // trap interrupt request pulse
	} rcsg_state_s;
endpackage

// ==== rtl/rcsg_regs.svh ====
// timing counts and reset values for the reset and clock switch guard
`ifndef RCSG_REGS_SVH
`define RCSG_REGS_SVH
`define RCSG_CLK_PERIOD_NS     100
`define RCSG_MAL_RST_FC        24
`define RCSG_MAL_RST_CYC       (`RCSG_MAL_RST_FC)
`define RCSG_EXT_RST_FC        12
`define RCSG_EXT_RST_CYC       (`RCSG_EXT_RST_FC)
`define RCSG_SYNC_CYC          4
`define RCSG_RESET_VECTOR_HI   16'hffff
`define RCSG_RESET_VECTOR_LO   16'hfffe
`define RCSG_XEN_BIT           7
`define RCSG_XTEN_BIT          6
`define RCSG_SYSCK_BIT         5
`define RCSG_SYSCTL_RST        8'hc0
`define RCSG_SFR_BASE          16'h0000
`define RCSG_SFR_TOP           16'h003f
`define RCSG_DBR_BASE          16'h0f80
`define RCSG_DBR_TOP           16'h0fff
`define RCSG_RAM_BASE          16'h0040
`define RCSG_RAM_TOP           16'h023f
`endif

// ==== tb/rcsg_pin_model.sv ====
// external reset circuit: pull-up, push button and the wired-low pin
`timescale 1ns/1ps
module rcsg_pin_model (
	// outside party
	input  wire logic hold_low_i,  // button holds the pin low
	// device side
	input  wire logic dev_d_i,     // open drain data
	input  wire logic dev_oe_i,    // device pulls the pin
	// resolved wire
	output logic      pin_o        // level seen by everyone
);
	// pull-up wins only when nobody pulls; the bench keeps the button down 12 cycles
	assign pin_o = hold_low_i ? 1'b0 : (dev_oe_i ? dev_d_i : 1'b1);
endmodule

// ==== tb/reset_and_clock_switch_guard_tb_top.sv ====
// sequence tests for the reset and clock switch guard
`timescale 1ns/1ps
module reset_and_clock_switch_guard_tb_top;
	logic clk_i = 0, rst_n_i = 0, hold = 0, reset_pin_i, reset_pin_o, reset_pin_oe_o;
	logic wdt_reset_req_i = 0, fetch_i = 0, ram_trap_select_i = 0, trap_to_reset_i = 1;
	logic trap_area_sfr_i = 1, trap_area_dbr_i = 1, sysctl_we_i = 0, int_reset_o, trap_int_o;
	logic fast_osc_en_o, slow_osc_en_o, cpu_on_slow_o, clear_int_state_o, clear_prescaler_o;
	logic watchdog_enable_o;
	logic [15:0] fetch_addr_i = 0, reset_vector_addr_o;
	logic [7:0]  sysctl_wdata_i = 0, system_control_two_o;
	int          fail_count = 0, n_checks = 0;
	// 10 MHz clock
	always #50 clk_i = ~clk_i;
	rcsg_pin_model pin (.hold_low_i(hold), .dev_d_i(reset_pin_o), .dev_oe_i(reset_pin_oe_o),
		.pin_o(reset_pin_i));
	rcsg_core uut (.clk_i, .rst_n_i, .reset_pin_i, .reset_pin_o, .reset_pin_oe_o,
		.wdt_reset_req_i, .fetch_i, .fetch_addr_i, .ram_trap_select_i, .trap_to_reset_i,
		.trap_area_sfr_i, .trap_area_dbr_i, .sysctl_we_i, .sysctl_wdata_i,
		.system_control_two_o, .int_reset_o, .trap_int_o, .fast_osc_en_o, .slow_osc_en_o,
		.cpu_on_slow_o, .clear_int_state_o, .clear_prescaler_o, .watchdog_enable_o,
		.reset_vector_addr_o);
	// compare and count
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// inputs always move 1 ns after the edge
	task step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task test_done;
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// bounded wait for the merged reset to drop; pin feedback stretches it
	task settle;
		int k;
		k = 0;
		while (int_reset_o !== 1'b0 && k < 80) begin
			step(1);
			k++;
		end
		if (k == 80) begin
			fail_count++;
			test_done;
		end
		step(2);
	endtask
	// merged reset state now, then pin drive length over a long window
	task count_oe(input int exp);
		int n;
		n = 0;
		chk({int_reset_o, clear_int_state_o, clear_prescaler_o}, (exp > 0) ? 3'h7 : 3'h0);
		repeat (40) begin
			if (reset_pin_oe_o === 1'b1) n++;
			step(1);
		end
		chk(16'(n), 16'(exp));
		settle;
	endtask
	// one-cycle strobes
	task wr(input logic [7:0] d);
		sysctl_we_i = 1;
		sysctl_wdata_i = d;
		step(1);
		sysctl_we_i = 0;
	endtask
	task ftch(input logic [15:0] a);
		fetch_i = 1;
		fetch_addr_i = a;
		step(1);
		fetch_i = 0;
	endtask
	initial begin
		step(12);
		rst_n_i = 1;
		settle;
		chk(system_control_two_o, 16'hc0);
		chk(reset_vector_addr_o, 16'hfffe);
		chk({watchdog_enable_o, cpu_on_slow_o}, 2'h2);
		wdt_reset_req_i = 1;
		step(1);
		wdt_reset_req_i = 0;
		count_oe(24);
		ftch(16'h003f);
		count_oe(24);
		ftch(16'h0f80);
		count_oe(24);
		ftch(16'h0040);
		count_oe(0);
		ram_trap_select_i = 1;
		ftch(16'h023f);
		count_oe(24);
		trap_to_reset_i = 0;
		ftch(16'h0000);
		chk(trap_int_o, 1);
		count_oe(0);
		trap_area_sfr_i = 0;
		ftch(16'h0010);
		chk(trap_int_o, 0);
		trap_to_reset_i = 1;
		wr(8'h00);
		count_oe(24);
		chk({fast_osc_en_o, slow_osc_en_o, system_control_two_o}, 16'h3c0);
		wr(8'h40);
		count_oe(24);
		wr(8'he0);
		step(1);
		wr(8'h60);
		count_oe(0);
		chk({slow_osc_en_o, cpu_on_slow_o}, 2'h3);
		wr(8'ha0);
		count_oe(24);
		wr(8'he0);
		step(1);
		wr(8'h60);
		step(1);
		wr(8'he0);
		step(1);
		wr(8'hc0);
		step(3);
		chk(cpu_on_slow_o, 1);
		step(1);
		chk(cpu_on_slow_o, 0);
		wr(8'he0);
		step(1);
		wr(8'h60);
		hold = 1;
		step(12);
		hold = 0;
		chk(int_reset_o, 1);
		settle;
		chk({cpu_on_slow_o, system_control_two_o}, 16'h0c0);
		chk(reset_pin_o, 0);
		wr(8'he0);
		rst_n_i = 0;
		step(2);
		chk({int_reset_o, system_control_two_o}, 16'h1c0);
		rst_n_i = 1;
		settle;
		chk({cpu_on_slow_o, int_reset_o}, 2'h0);
		test_done;
	end
endmodule
